/* irke_encoder.sv */
// Overview of operation
// - scan 7 drives by 7 senses, 64 codes
// - standby holds all drives on; sense wakes
// - oscillator first, debounce, then drives successively
// - highest strapped drive line below line 6 sets the group
// - group bits 111 open, 000 upward to 101
// - drive line 6 strapped selects modulated mode
// - strap pull-down in standby, pull-up when active
// - latch mode and group once; command updates
// - strap change alone starts nothing
// - multiple keys block words, shorten scan period
// - grounded sense key overrides its line's keys
// - senses 5 and 6 together give 56-63
// - command follows the key currently sensed
// - repeat words while held, finish started word
// - word: toggles, group msb first, command F..A
// - modulated mode leads with fixed 3-unit bit
// - spacing 2 units for 0, 3 for 1
// - toggles count on release, frozen during multi
// - pulse unit 1152, word period 55296 oscillator periods
// - carrier 12 periods low 8 high 4; flash 4
module irke_encoder #(
    parameter int OSC_DIV        = irke_pkg::OSC_DIV,
    parameter int PULSE_UNIT_OSC = irke_pkg::PULSE_UNIT_OSC,
    parameter int WORD_OSC       = irke_pkg::WORD_OSC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // key matrix, open drain drives
    output logic      [6:0]  scan_drive_o,
    output logic      [6:0]  scan_drive_oe,
    input  wire logic [6:0]  key_sense,
    // strap
    input  wire logic        address_mode_strap,
    output logic             strap_pullup_en,
    output logic             strap_pulldown_en,
    // emitter and oscillator
    output logic             ir_output,
    output logic             osc_active
);
    localparam int TW = irke_pkg::TW;
    localparam logic [TW-1:0] PU         = TW'(PULSE_UNIT_OSC);
    localparam logic [TW-1:0] DEB_END    = TW'(irke_pkg::DEBOUNCE_UNITS * PULSE_UNIT_OSC - 1);
    localparam logic [TW-1:0] REL_END    = TW'(irke_pkg::RELEASE_UNITS * PULSE_UNIT_OSC - 1);
    localparam logic [TW-1:0] GAP_NORMAL = TW'(irke_pkg::SCAN_GAP_UNITS * PULSE_UNIT_OSC - 1);
    localparam logic [TW-1:0] GAP_MULTI  = TW'(irke_pkg::MULTI_GAP_UNITS * PULSE_UNIT_OSC - 1);
    localparam logic [TW-1:0] SP0        = TW'(irke_pkg::BIT0_UNITS * PULSE_UNIT_OSC - 1);
    localparam logic [TW-1:0] SP1        = TW'(irke_pkg::BIT1_UNITS * PULSE_UNIT_OSC - 1);
    localparam logic [TW-1:0] WORD_END   = TW'(WORD_OSC - 1);
    localparam logic [TW-1:0] FLASH_END  = TW'(irke_pkg::FLASH_OSC - 1);
    localparam logic [TW-1:0] MOD_END    = TW'(irke_pkg::CARRIER_OSC * irke_pkg::MOD_PULSES - 1);
    localparam logic [3:0]    CAR_END    = 4'(irke_pkg::CARRIER_OSC - 1);
    localparam logic [3:0]    CAR_LOW    = 4'(irke_pkg::CARRIER_LOW_OSC);
    localparam logic [4:0]    SLOT_END   = 5'(irke_pkg::SCAN_SLOT_OSC - 1);
    localparam logic [2:0]    LAST_SLOT  = 3'(irke_pkg::GND_SLOT);
    localparam logic [3:0]    PULSES     = 4'(irke_pkg::WORD_BITS + 1);

    if (OSC_DIV < 1 || PULSE_UNIT_OSC < 4 || WORD_OSC < 16 * PULSE_UNIT_OSC || WORD_OSC >= (1 << TW)) begin : g_bad
        $error("irke_encoder: timing parameters out of range");
    end

    // key decode: count of keys found and the last code seen
    function automatic logic [12:0] irke_decode(input logic [7:0][6:0] sn);
        logic [6:0] gnd;
        logic [6:0] cnt;
        logic [5:0] code;
        logic       pair;
        gnd  = ~sn[irke_pkg::GND_SLOT];
        cnt  = 7'h00;
        code = 6'h00;
        for (int s = 0; s < irke_pkg::LINES; s++) begin
            if (gnd[s]) begin
                cnt  = (s == 6 && gnd[5]) ? cnt : cnt + 7'h01;
                code = (s == 6 && gnd[5]) ? 6'(irke_pkg::SLOTS * irke_pkg::SLOTS - 1) : 6'(s * 8 + 7);
            end else begin
                for (int d = 0; d < irke_pkg::LINES; d++) begin
                    pair = !gnd[5] && !gnd[6] && !sn[d][5] && !sn[d][6];
                    if (pair && s >= 5) begin
                        if (s == 5) begin
                            cnt  = cnt + 7'h01;
                            code = 6'(56 + d);
                        end
                    end else if (!sn[d][s]) begin
                        cnt  = cnt + 7'h01;
                        code = 6'(s * 8 + d);
                    end
                end
            end
        end
        return {cnt, code};
    endfunction : irke_decode

    // group from the highest strapped drive line below the mode line
    function automatic logic [2:0] irke_group(input logic [6:0] hit);
        logic [2:0] g;
        g = irke_pkg::GROUP_OPEN;
        for (int d = 0; d < irke_pkg::MODE_LINE; d++) begin
            if (hit[d]) begin
                g = 3'(d);
            end
        end
        return g;
    endfunction : irke_group

    irke_pkg::irke_state_t state;
    logic [6:0]      sense_meta, sense_sync;
    logic            strap_meta, strap_sync;
    logic [15:0]     div_cnt;
    logic            osc_run, osc_tick;
    logic [TW-1:0]   wait_cnt;
    logic [2:0]      slot;
    logic [4:0]      slot_tick;
    logic [7:0][6:0] snap;
    logic [6:0]      strap_hit;
    logic [12:0]     dec;
    logic            first_done, key_ok, multi_seq, mode_mod, ctrl_enable;
    logic [2:0]      group_bits;
    logic [5:0]      command;
    logic [1:0]      toggle;
    logic [TW-1:0]   word_cnt, gap_cnt, pulse_pos;
    logic            tx_busy, tx_start, pulse_on;
    logic [10:0]     tx_shift;
    logic [3:0]      pulses_left, car_pos;
    logic            acc_wr;
    logic [7:0]      acc_addr;
    logic [31:0]     rd_value;

    // two-flop synchronisers for pins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sense_meta <= 7'h7f;
            sense_sync <= 7'h7f;
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            sense_meta <= key_sense;
            sense_sync <= sense_meta;
            strap_meta <= address_mode_strap;
            strap_sync <= strap_meta;
        end
    end

    // oscillator divider runs only while active or finishing a word
    assign osc_run  = (state != irke_pkg::S_STANDBY) || tx_busy;
    assign osc_tick = osc_run && (div_cnt == 16'(OSC_DIV - 1));
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt    <= 16'h0000;
            osc_active <= 1'b0;
        end else begin
            osc_active <= osc_run;
            if (!osc_run || osc_tick) begin
                div_cnt <= 16'h0000;
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end

    assign dec = irke_decode(snap);

    // scan sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= irke_pkg::S_STANDBY;
            wait_cnt  <= '0;
            slot      <= 3'h0;
            slot_tick <= 5'h00;
            snap      <= '1;
            strap_hit <= 7'h00;
        end else begin
            unique case (state)
                irke_pkg::S_STANDBY: begin
                    wait_cnt <= '0;
                    if (ctrl_enable && sense_sync != 7'h7f) begin
                        state <= irke_pkg::S_DEBOUNCE;
                    end
                end
                irke_pkg::S_DEBOUNCE: begin
                    if (osc_tick) begin
                        wait_cnt <= wait_cnt + 1'b1;
                        if (wait_cnt == DEB_END) begin
                            state     <= irke_pkg::S_SCAN;
                            slot      <= 3'h0;
                            slot_tick <= 5'h00;
                        end
                    end
                end
                irke_pkg::S_SCAN: begin
                    if (osc_tick) begin
                        slot_tick <= slot_tick + 5'h01;
                        if (slot_tick == SLOT_END) begin
                            slot_tick       <= 5'h00;
                            snap[slot]      <= sense_sync;
                            strap_hit[slot[2:0] == LAST_SLOT ? 3'h0 : slot] <=
                                (slot == LAST_SLOT) ? strap_hit[0] : !strap_sync;
                            slot            <= slot + 3'h1;
                            if (slot == LAST_SLOT) begin
                                state <= irke_pkg::S_EVAL;
                            end
                        end
                    end
                end
                irke_pkg::S_EVAL: begin
                    wait_cnt <= (dec[12:6] > 7'h01) ? GAP_MULTI : GAP_NORMAL;
                    state    <= (dec[12:6] == 7'h00) ? irke_pkg::S_RELEASE : irke_pkg::S_PAUSE;
                    if (dec[12:6] == 7'h00) begin
                        wait_cnt <= '0;
                    end
                end
                irke_pkg::S_PAUSE: begin
                    if (osc_tick) begin
                        wait_cnt <= wait_cnt - 1'b1;
                        if (wait_cnt == '0) begin
                            state <= irke_pkg::S_SCAN;
                            slot  <= 3'h0;
                        end
                    end
                end
                irke_pkg::S_RELEASE: begin
                    if (sense_sync != 7'h7f) begin
                        state    <= irke_pkg::S_DEBOUNCE;
                        wait_cnt <= '0;
                    end else if (osc_tick) begin
                        wait_cnt <= wait_cnt + 1'b1;
                        if (wait_cnt == REL_END) begin
                            state <= irke_pkg::S_STANDBY;
                        end
                    end
                end
                default: state <= irke_pkg::S_STANDBY;
            endcase
        end
    end

    // drives: all on outside a scan, one at a time inside
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scan_drive_oe     <= 7'h7f;
            strap_pullup_en   <= 1'b0;
            strap_pulldown_en <= 1'b1;
        end else begin
            strap_pullup_en   <= (state != irke_pkg::S_STANDBY);
            strap_pulldown_en <= (state == irke_pkg::S_STANDBY);
            if (state == irke_pkg::S_SCAN) begin
                scan_drive_oe <= (slot == LAST_SLOT) ? 7'h00 : 7'(7'h01 << slot);
            end else begin
                scan_drive_oe <= 7'h7f;
            end
        end
    end
    assign scan_drive_o = 7'h00;

    // latched word contents and key status
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_done <= 1'b0;
            key_ok     <= 1'b0;
            multi_seq  <= 1'b0;
            mode_mod   <= 1'b0;
            group_bits <= irke_pkg::GROUP_OPEN;
            command    <= 6'h00;
            toggle     <= 2'h0;
        end else if (state == irke_pkg::S_EVAL) begin
            first_done <= 1'b1;
            if (!first_done) begin
                mode_mod   <= strap_hit[irke_pkg::MODE_LINE];
                group_bits <= irke_group(strap_hit);
            end
            key_ok <= (dec[12:6] == 7'h01);
            if (dec[12:6] > 7'h01) begin
                multi_seq <= 1'b1;
            end
            if (dec[12:6] == 7'h01) begin
                command <= dec[5:0];
            end
        end else if (state == irke_pkg::S_RELEASE) begin
            key_ok <= 1'b0;
            if (osc_tick && wait_cnt == REL_END && sense_sync == 7'h7f) begin
                toggle     <= toggle + 2'h1;
                first_done <= 1'b0;
                multi_seq  <= 1'b0;
            end
        end
    end

    // word repetition timer, restarted by each word
    assign tx_start = osc_tick && key_ok && !tx_busy && (word_cnt == WORD_END);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_cnt <= WORD_END;
        end else if (!osc_run) begin
            word_cnt <= WORD_END;
        end else if (tx_start) begin
            word_cnt <= '0;
        end else if (osc_tick && word_cnt != WORD_END) begin
            word_cnt <= word_cnt + 1'b1;
        end
    end

    // pulse-distance transmitter
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_busy     <= 1'b0;
            tx_shift    <= 11'h000;
            pulses_left <= 4'h0;
            gap_cnt     <= '0;
            pulse_on    <= 1'b0;
            pulse_pos   <= '0;
            car_pos     <= 4'h0;
        end else if (tx_start) begin
            tx_busy     <= 1'b1;
            tx_shift    <= {mode_mod | toggle[1], toggle[0], group_bits, command};
            pulses_left <= PULSES;
            gap_cnt     <= '0;
        end else if (tx_busy && osc_tick) begin
            if (pulse_on) begin
                pulse_pos <= pulse_pos + 1'b1;
                car_pos   <= (car_pos == CAR_END) ? 4'h0 : car_pos + 4'h1;
                if (pulse_pos == (mode_mod ? MOD_END : FLASH_END)) begin
                    pulse_on <= 1'b0;
                end
            end
            if (gap_cnt != '0) begin
                gap_cnt <= gap_cnt - 1'b1;
            end else if (pulses_left != 4'h0) begin
                pulse_on    <= 1'b1;
                pulse_pos   <= '0;
                car_pos     <= 4'h0;
                pulses_left <= pulses_left - 4'h1;
                gap_cnt     <= tx_shift[10] ? SP1 : SP0;
                tx_shift    <= {tx_shift[9:0], 1'b0};
            end else if (!pulse_on) begin
                tx_busy <= 1'b0;
            end
        end
    end

    // emitter output, low whenever no pulse is active
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ir_output <= 1'b0;
        end else begin
            ir_output <= tx_busy && pulse_on && (!mode_mod || car_pos >= CAR_LOW);
        end
    end

    // ahb-lite slave, zero wait states, reads captured in address phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_comb begin
        unique case (haddr[7:0])
            irke_pkg::ADDR_CTRL:   rd_value = {31'h0, ctrl_enable};
            irke_pkg::ADDR_STATUS: rd_value = {18'h0, state, 3'h0, mode_mod, multi_seq, key_ok, tx_busy, osc_run};
            irke_pkg::ADDR_CODE:   rd_value = {21'h0, toggle, group_bits, command};
            default:               rd_value = 32'h0;
        endcase
        if (haddr[31:8] != 24'h0) begin
            rd_value = 32'h0;
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_wr   <= 1'b0;
            acc_addr <= 8'h00;
            hrdata   <= 32'h0;
        end else if (hsel && htrans[1] && hready) begin
            acc_wr   <= hwrite && (haddr[31:8] == 24'h0);
            acc_addr <= haddr[7:0];
            if (!hwrite) begin
                hrdata <= rd_value;
            end
        end else begin
            acc_wr <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_enable <= irke_pkg::CTRL_RESET[irke_pkg::CTRL_EN_BIT];
        end else if (acc_wr && acc_addr == irke_pkg::ADDR_CTRL) begin
            ctrl_enable <= hwdata[irke_pkg::CTRL_EN_BIT];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_standby_drive_all: assert property ((state == irke_pkg::S_STANDBY) |=> ##1 (scan_drive_oe == 7'h7f) || $past(state) != irke_pkg::S_STANDBY) else $error("drives not all on in standby");
    a_scan_one_drive: assert property ((state == irke_pkg::S_SCAN && $past(state) == irke_pkg::S_SCAN) |-> $onehot0(scan_drive_oe)) else $error("more than one drive during scan");
    a_strap_pull_sel: assert property ((state == irke_pkg::S_STANDBY && $past(state) == irke_pkg::S_STANDBY) |-> strap_pulldown_en && !strap_pullup_en) else $error("strap pulls wrong in standby");
    a_strap_no_wake: assert property ((state == irke_pkg::S_STANDBY && sense_sync == 7'h7f) |=> state == irke_pkg::S_STANDBY) else $error("woke without a key");
    a_no_start_multi: assert property ((state == irke_pkg::S_EVAL && dec[12:6] > 7'h01) |=> ##1 !tx_start [*2]) else $error("word started on multiple keys");
    a_toggle_frozen: assert property ((multi_seq && state != irke_pkg::S_RELEASE) |=> $stable(toggle)) else $error("toggle moved during multiple keys");
    a_group_held: assert property ((first_done && state != irke_pkg::S_RELEASE) |=> $stable(group_bits) && $stable(mode_mod)) else $error("group re-sensed");
    a_lead_bit_mod: assert property ((tx_start && mode_mod) |=> tx_shift[10] && pulses_left == PULSES) else $error("modulated word lacks lead bit");
    a_ir_low_idle: assert property ((!tx_busy || !pulse_on) |=> !ir_output) else $error("output high outside a pulse");
    a_osc_stops: assert property ((state == irke_pkg::S_STANDBY && !tx_busy) |=> !osc_active) else $error("oscillator runs in standby");
endmodule : irke_encoder

/* irke_pkg.sv */
package irke_pkg;
    // matrix shape
    localparam int LINES     = 7;
    localparam int SLOTS     = 8;
    localparam int GND_SLOT  = 7;
    localparam int WORD_BITS = 11;
    localparam int CODE_W    = 6;
    localparam int GROUP_W   = 3;
    localparam int TW        = 20;
    // clock and oscillator timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int OSC_PERIOD_NS   = 2200;
    localparam int OSC_DIV         = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PULSE_UNIT_OSC  = 1152;
    localparam int WORD_OSC        = 55296;
    localparam int FLASH_OSC       = 4;
    localparam int CARRIER_OSC     = 12;
    localparam int CARRIER_LOW_OSC = 8;
    localparam int MOD_PULSES      = 6;
    localparam int SCAN_SLOT_OSC   = 16;
    // spacings and waits in pulse units
    localparam int BIT0_UNITS      = 2;
    localparam int BIT1_UNITS      = 3;
    localparam int DEBOUNCE_UNITS  = 5;
    localparam int MULTI_GAP_UNITS = 8;
    localparam int SCAN_GAP_UNITS  = 12;
    localparam int RELEASE_UNITS   = 1;
    // strap decode
    localparam logic [2:0] GROUP_OPEN = 3'h7;
    localparam int         MODE_LINE  = 6;
    // register map
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_CODE   = 8'h08;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
    localparam int          CTRL_EN_BIT = 0;
    // sequencer states
    typedef enum logic [5:0] {
        S_STANDBY  = 6'h01,
        S_DEBOUNCE = 6'h02,
        S_SCAN     = 6'h04,
        S_EVAL     = 6'h08,
        S_PAUSE    = 6'h10,
        S_RELEASE  = 6'h20
    } irke_state_t;
endpackage : irke_pkg

/* irke_keypad.sv */
module irke_keypad (
    // matrix side
    input  wire logic [6:0]  scan_drive_oe,
    output logic      [6:0]  key_sense,
    // strap side
    input  wire logic        strap_pullup_en,
    output logic             address_mode_strap,
    // scenario control: bit s*8+d closes a key, d=7 means grounded
    input  wire logic [63:0] keys,
    input  wire logic [6:0]  strap_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] act;

    // ground acts as an always-conducting eighth drive
    assign act = {1'b1, scan_drive_oe};

    // a closed key on a conducting drive pulls its sense line low
    always_comb begin
        for (int s = 0; s < 7; s++) begin
            key_sense[s] = 1'b1;
            for (int d = 0; d < 8; d++) begin
                if (keys[s*8+d] && act[d]) key_sense[s] = 1'b0;
                if (s > 4 && keys[56+d] && act[d]) key_sense[s] = 1'b0;
            end
        end
    end

    // diodes from wired drives pull the strap low, else the enabled load wins
    assign address_mode_strap = |(strap_lines & scan_drive_oe) ? 1'b0 : strap_pullup_en;
endmodule : irke_keypad

/* irke_encoder_tb.sv */
module irke_encoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int UNIT = 64;
    localparam int WORD = 48 * UNIT;
    logic        sys_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, ir_q = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0, tog = '0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, pu, pd, ir_output, osc_active, address_mode_strap;
    logic [6:0]  scan_drive_oe, key_sense, strap_lines = '0;
    logic [63:0] keys = '0;
    int          n_mismatch = 0, total_checks = 0, cyc = 0, last_rise = -1000, hi_start = 0;
    int          starts[$];

    // free-running bench clock
    always #20 sys_clk = ~sys_clk;

    irke_encoder #(.OSC_DIV(1), .PULSE_UNIT_OSC(UNIT), .WORD_OSC(WORD)) u_dut (
        .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .scan_drive_o(), .scan_drive_oe,
        .key_sense, .address_mode_strap, .strap_pullup_en(pu), .strap_pulldown_en(pd),
        .ir_output, .osc_active);
    irke_keypad u_keys (.scan_drive_oe, .key_sense, .strap_pullup_en(pu),
        .address_mode_strap, .keys, .strap_lines);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic guard(input int n);
        check(n < 20000, 1);
        if (n >= 20000) summarize();
    endtask : guard

    // burst starts, pulse widths and carrier period on the emitter output
    always @(posedge sys_clk) begin
        cyc++;
        if (ir_output === 1'b1 && !ir_q) begin
            if (cyc - last_rise > 40) starts.push_back(cyc);
            else check(cyc - last_rise, 12);
            last_rise = cyc;
            hi_start = cyc;
        end
        if (ir_output === 1'b0 && ir_q) check(cyc - hi_start, 4);
        ir_q = (ir_output === 1'b1);
    end

    // one single ahb-lite transfer, read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 20000);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 20000);
        rd = hrdata;
        check(hresp, 1'b0);
        guard(n);
    endtask : bus

    task automatic wait_starts(input int want);
        int n;
        n = 0;
        while (starts.size() < want && n < 20000) begin @(posedge sys_clk); n++; end
        guard(n);
    endtask : wait_starts

    // turn pulse spacings into an eleven bit word
    task automatic decode(input int k, output logic [10:0] w);
        int iv;
        for (int i = 0; i < 11; i++) begin
            iv = starts[k+i+1] - starts[k+i];
            check((iv == 2 * UNIT) || (iv == 3 * UNIT), 1);
            w[10-i] = (iv == 3 * UNIT);
        end
    endtask : decode

    // press, two words with release inside the second, then back to sleep
    task automatic press(input logic [63:0] k, input logic [6:0] sl, input logic md,
                         input logic [2:0] grp, input logic [5:0] cmd);
        logic [10:0] w, exp;
        int          n;
        exp = {md | tog[1], tog[0], grp, cmd};
        n = 0;
        starts.delete();
        strap_lines <= sl;
        keys <= k;
        @(posedge sys_clk);
        if (osc_active === 1'b0) begin
            while (scan_drive_oe === 7'h7f && n < 2000) begin @(posedge sys_clk); n++; end
            check(n >= 4 * UNIT && n <= 9 * UNIT + 4, 1);
        end
        wait_starts(13);
        check(pu, 1);
        strap_lines <= ~sl;
        keys <= '0;
        wait_starts(24);
        check(starts[12] - starts[0], WORD);
        decode(0, w);
        check(w, exp);
        decode(12, w);
        check(w, exp);
        tog = tog + 2'h1;
        bus(0, 8'h08, 0);
        check(rd[10:0], {tog, exp[8:0]});
        n = 0;
        while (osc_active !== 1'b0 && n < 20000) begin @(posedge sys_clk); n++; end
        guard(n);
        check(starts.size(), 24);
        check({scan_drive_oe, pd, pu, ir_output}, {7'h7f, 3'b100});
    endtask : press

    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check({scan_drive_oe, pd, pu, ir_output, osc_active}, {7'h7f, 4'b1000});
        bus(0, 8'h00, 0);
        check(rd, 32'h1);
        bus(0, 8'h0c, 0);
        check(rd, 32'h0);
        bus(0, 8'h04, 0);
        check(rd[13:8], 6'h01);
        strap_lines <= 7'h4a;
        repeat (600) @(posedge sys_clk);
        check(osc_active, 0);
        bus(1, 8'h00, 0);
        keys <= 64'h1;
        repeat (600) @(posedge sys_clk);
        check(osc_active, 0);
        keys <= '0;
        bus(1, 8'h00, 1);
        press(64'h1 << 43, 7'h0a, 0, 3'h3, 6'd43);
        press(64'h1 << 58, 7'h44, 1, 3'h2, 6'd58);
        press((64'h1 << 23) | (64'h1 << 17), 7'h00, 0, 3'h7, 6'd23);
        press(64'h1 << 63, 7'h21, 0, 3'h5, 6'd63);
        starts.delete();
        strap_lines <= '0;
        keys <= 64'h202;
        repeat (1500) @(posedge sys_clk);
        check(starts.size(), 0);
        bus(0, 8'h04, 0);
        check(rd[3], 1);
        press(64'h200, 7'h00, 0, 3'h7, 6'd9);
        summarize();
    end
endmodule : irke_encoder_tb
